/* scr_pkg.sv */
/*
 * Package of the serial channel register map: offsets, field positions,
 * reset values and the carrier structs shared by the design files.
 * Assumes a single 100 MHz clock domain and a synchronous active-low reset.
 */
package scr_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_DATA      = 3'h0;
    localparam logic [2:0] OFS_INT_EN    = 3'h1;
    localparam logic [2:0] OFS_IDENT     = 3'h2;
    localparam logic [2:0] OFS_LINE_SET  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
    localparam logic [2:0] OFS_LINE_ST   = 3'h5;
    localparam logic [2:0] OFS_MODEM_ST  = 3'h6;
    localparam logic [2:0] OFS_SCRATCH   = 3'h7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FC_ENABLE   = 0;
    localparam int FC_RX_FLUSH = 1;
    localparam int FC_TX_FLUSH = 2;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_TRIG_LO  = 6;
    localparam int FC_TRIG_HI  = 7;
    localparam int LS_DIV_SEL  = 7;

    // ----------------------------------------------------------------
    // Reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [3:0] INT_EN_MASK   = 4'hF;
    localparam logic [5:0] MODEM_CTL_MSK = 6'h3F;
    localparam int         FIFO_DEPTH    = 4;
    localparam int         FIFO_WIDTH    = 8;
    localparam logic [4:0] TRIG_1        = 5'h01;
    localparam logic [4:0] TRIG_4        = 5'h04;
    localparam logic [4:0] TRIG_8        = 5'h08;
    localparam logic [4:0] TRIG_14       = 5'h0E;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } scr_bus_req_t;

    typedef struct packed {
        logic [1:0] trig;
        logic       dma_mode;
        logic       enable;
    } scr_fifo_ctl_t;
endpackage

/* scr_fifo.sv */
/*
 * Small flip-flop FIFO with valid/ready on both sides and a flush input.
 * Assumes flush and traffic share the clock of the instantiating block.
 */
`timescale 1ns/1ps
module scr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    output logic      [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign count_o     = cnt_r;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            if (push && !flush_i) begin
                mem_r[wp_r] <= in_data_i;
            end
        end
    end
endmodule // scr_fifo

/* scr_regs.sv */
/*
 * Register map and FIFO control of one serial channel.
 * Assumes the host drives a synchronous 3-bit address, read and write strobes,
 * and that the receiver and transmitter engines sit outside this block.
 */
`timescale 1ns/1ps
// Functional notes
// - Eight byte registers, selected by a 3-bit address, carry all access.
// - Line settings bit 7 redirects offsets 0 and 1 to the divisor bytes.
// - Offset 2 writes FIFO control and reads interrupt identification.
// - FIFO control bit 0 enables both FIFOs; toggling it empties both. Both 4-byte FIFOs here still queue data while bit 0 is clear.
// - Writes with bit 0 clear leave other FIFO control bits unchanged.
// - Bit 1 flushes the receive FIFO only, and clears itself.
// - Bit 2 flushes the transmit FIFO only, and clears itself.
// - With FIFOs enabled, bit 3 selects DMA ready signalling mode 1.
// - FIFO control bits 4 and 5 are reserved and ignored.
// - Bits 7:6 set receive threshold to 1, 4, 8 or 14 bytes.
// - Bit 0 of each data register is the first serial bit.
// - Without FIFOs, identification bits 3, 7:6 and line state bit 7 read zero.
// - Identification bits 7:6 read set while FIFO enable is set.
module scr_regs (
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire scr_pkg::scr_bus_req_t bus_i,
    output logic                [7:0]  rdata_o,
    input  wire logic                  rx_valid_i,
    input  wire logic           [7:0]  rx_data_i,
    output logic                       rx_ready_o,
    output logic                       tx_valid_o,
    output logic                [7:0]  tx_data_o,
    input  wire logic                  tx_ready_i,
    input  wire logic           [3:0]  int_id_i,
    input  wire logic           [7:0]  line_state_i,
    input  wire logic           [7:0]  modem_state_i,
    output logic               [15:0]  divisor_o,
    output logic                [7:0]  line_settings_o,
    output logic                [5:0]  modem_control_o,
    output logic                [3:0]  interrupt_enable_o,
    output scr_pkg::scr_fifo_ctl_t     fifo_ctl_o,
    output logic                       rx_trigger_hit_o,
    output logic                       receive_ready_out_o,
    output logic                       transmit_ready_out_o
);
    import scr_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]    div_lo_r, div_lo_nxt, div_hi_r, div_hi_nxt;
    logic [7:0]    lset_r, lset_nxt, scratch_r, scratch_nxt;
    logic [3:0]    ien_r, ien_nxt;
    logic [5:0]    mctl_r, mctl_nxt;
    scr_fifo_ctl_t fctl_r, fctl_nxt;
    logic          rx_flush, tx_flush, div_sel, tx_push, rx_pop;
    logic [2:0]    rx_cnt, tx_cnt;
    logic [4:0]    trig_lvl;
    logic [7:0]    rx_head;
    logic          rx_has, tx_room;

    function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
        case (sel)
            2'h0:    trig_bytes = TRIG_1;
            2'h1:    trig_bytes = TRIG_4;
            2'h2:    trig_bytes = TRIG_8;
            default: trig_bytes = TRIG_14;
        endcase
    endfunction

    assign div_sel = lset_r[LS_DIV_SEL];

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    always_comb begin
        div_lo_nxt  = div_lo_r;
        div_hi_nxt  = div_hi_r;
        lset_nxt    = lset_r;
        scratch_nxt = scratch_r;
        ien_nxt     = ien_r;
        mctl_nxt    = mctl_r;
        fctl_nxt    = fctl_r;
        rx_flush    = 1'b0;
        tx_flush    = 1'b0;
        tx_push     = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                OFS_DATA: begin
                    if (div_sel) begin
                        div_lo_nxt = bus_i.wdata;
                    end else begin
                        tx_push = 1'b1;
                    end
                end
                OFS_INT_EN: begin
                    if (div_sel) begin
                        div_hi_nxt = bus_i.wdata;
                    end else begin
                        ien_nxt = bus_i.wdata[3:0] & INT_EN_MASK;
                    end
                end
                OFS_IDENT: begin
                    if (bus_i.wdata[FC_ENABLE] != fctl_r.enable) begin
                        rx_flush = 1'b1;
                        tx_flush = 1'b1;
                    end
                    fctl_nxt.enable = bus_i.wdata[FC_ENABLE];
                    if (bus_i.wdata[FC_ENABLE]) begin
                        if (bus_i.wdata[FC_RX_FLUSH]) begin
                            rx_flush = 1'b1;
                        end
                        if (bus_i.wdata[FC_TX_FLUSH]) begin
                            tx_flush = 1'b1;
                        end
                        fctl_nxt.dma_mode = bus_i.wdata[FC_DMA_MODE];
                        // threshold select, bits 4 and 5 ignored
                        fctl_nxt.trig = bus_i.wdata[FC_TRIG_HI:FC_TRIG_LO];
                    end
                end
                OFS_LINE_SET: lset_nxt = bus_i.wdata;
                OFS_MODEM_CTL: mctl_nxt = bus_i.wdata[5:0] & MODEM_CTL_MSK;
                OFS_SCRATCH: scratch_nxt = bus_i.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lset_r <= RST_BYTE;
            ien_r  <= RST_BYTE[3:0];
            mctl_r <= RST_BYTE[5:0];
            fctl_r <= scr_fifo_ctl_t'(RST_BYTE[3:0]);
        end else begin
            lset_r <= lset_nxt;
            ien_r  <= ien_nxt;
            mctl_r <= mctl_nxt;
            fctl_r <= fctl_nxt;
        end
        div_lo_r    <= div_lo_nxt;
        div_hi_r    <= div_hi_nxt;
        scratch_r   <= scratch_nxt;
    end

    // ----------------------------------------------------------------
    // Data FIFOs
    // ----------------------------------------------------------------
    assign rx_pop = bus_i.rd && (bus_i.addr == OFS_DATA) && !div_sel;

    scr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (rx_flush),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_data_i),
        .out_valid_o (rx_has),
        .out_ready_i (rx_pop),
        .out_data_o  (rx_head),
        .count_o     (rx_cnt)
    );

    scr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (tx_flush),
        .in_valid_i  (tx_push),
        .in_ready_o  (tx_room),
        .in_data_i   (bus_i.wdata),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o),
        .count_o     (tx_cnt)
    );

    // ----------------------------------------------------------------
    // Read mux and status
    // ----------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_DATA:      rdata_nxt = div_sel ? div_lo_r : rx_head;
                OFS_INT_EN:    rdata_nxt = div_sel ? div_hi_r : {4'h0, ien_r};
                OFS_IDENT:     rdata_nxt = {{2{fctl_r.enable}}, 2'b00,
                                            int_id_i[3] & fctl_r.enable, int_id_i[2:0]};
                OFS_LINE_SET:  rdata_nxt = lset_r;
                OFS_MODEM_CTL: rdata_nxt = {2'b00, mctl_r};
                OFS_LINE_ST:   rdata_nxt = {line_state_i[7] & fctl_r.enable, line_state_i[6:0]};
                OFS_MODEM_ST:  rdata_nxt = modem_state_i;
                OFS_SCRATCH:   rdata_nxt = scratch_r;
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_r <= RST_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o            = rdata_r;
    assign divisor_o          = {div_hi_r, div_lo_r};
    assign line_settings_o    = lset_r;
    assign modem_control_o    = mctl_r;
    assign interrupt_enable_o = ien_r;
    assign fifo_ctl_o         = fctl_r;
    assign trig_lvl           = trig_bytes(fctl_r.trig);
    assign rx_trigger_hit_o   = fctl_r.enable && ({2'b00, rx_cnt} >= trig_lvl);

    always_comb begin
        if (fctl_r.enable && fctl_r.dma_mode) begin
            receive_ready_out_o  = rx_trigger_hit_o;
            transmit_ready_out_o = tx_room;
        end else begin
            receive_ready_out_o  = rx_has;
            transmit_ready_out_o = (tx_cnt == 3'h0);
        end
    end
endmodule // scr_regs

/* scr_host.sv */
/* Host model that drives the register port of scr_regs.
   Assumes the bench calls its tasks; strobes change at falling edges. */
`timescale 1ns/1ps
module scr_host (
    input  wire logic                   clock_i,
    output scr_pkg::scr_bus_req_t       bus_o,
    input  wire logic             [7:0] rdata_i
);
    import scr_pkg::*;
    initial bus_o = '0;
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock_i);
        bus_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clock_i);
        bus_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clock_i);
        bus_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'hA5};
        @(negedge clock_i);
        bus_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'h5A};
        d = rdata_i;
    endtask
endmodule // scr_host

/* scr_regs_chk.sv */
/* Checker of the serial channel register map.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module scr_regs_chk (
    input wire logic                   clock_i,
    input wire logic                   rst_n_i,
    input wire scr_pkg::scr_bus_req_t  bus_i,
    input wire logic             [7:0] rdata_o,
    input wire logic             [3:0] int_id_i,
    input wire logic            [15:0] divisor_o,
    input wire logic             [7:0] line_settings_o,
    input wire logic             [3:0] interrupt_enable_o,
    input wire scr_pkg::scr_fifo_ctl_t fifo_ctl_o,
    input wire logic                   rx_valid_i,
    input wire logic                   rx_trigger_hit_o,
    input wire logic                   receive_ready_out_o,
    input wire logic                   tx_valid_o
);
    import scr_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence fc_wr; bus_i.wr && bus_i.addr == OFS_IDENT; endsequence
    sequence fc_on; fc_wr ##0 bus_i.wdata[FC_ENABLE]; endsequence
    sequence dv_wr; bus_i.wr && bus_i.addr[2:1] == 2'b00 && line_settings_o[LS_DIV_SEL]; endsequence
    a_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_ident_read: assert property (bus_i.rd && bus_i.addr == OFS_IDENT |=> rdata_o ==
        {{2{$past(fifo_ctl_o.enable)}}, 2'b00, $past(fifo_ctl_o.enable) & $past(int_id_i[3]), $past(int_id_i[2:0])})
        else $error("identification read wrong");
    a_fc_enable: assert property (fc_wr |=> fifo_ctl_o.enable == $past(bus_i.wdata[FC_ENABLE]))
        else $error("fifo enable not taken");
    a_fc_program: assert property (fc_on |=> fifo_ctl_o.trig == $past(bus_i.wdata[7:6]) &&
        fifo_ctl_o.dma_mode == $past(bus_i.wdata[FC_DMA_MODE])) else $error("fifo control not programmed");
    a_fc_keep: assert property (fc_wr ##0 !bus_i.wdata[FC_ENABLE] |=> $stable(fifo_ctl_o.trig) &&
        $stable(fifo_ctl_o.dma_mode)) else $error("fifo control changed without enable");
    a_rx_flush: assert property (fc_on ##0 bus_i.wdata[FC_RX_FLUSH] && !rx_valid_i |=>
        !receive_ready_out_o && !rx_trigger_hit_o) else $error("receive fifo not flushed");
    a_tx_flush: assert property (fc_on ##0 bus_i.wdata[FC_TX_FLUSH] |=> !tx_valid_o)
        else $error("transmit fifo not flushed");
    a_div_low: assert property (dv_wr ##0 !bus_i.addr[0] |=> divisor_o[7:0] == $past(bus_i.wdata))
        else $error("divisor low byte wrong");
    a_div_high: assert property (dv_wr ##0 bus_i.addr[0] |=> divisor_o[15:8] == $past(bus_i.wdata))
        else $error("divisor high byte wrong");
    a_int_en_write: assert property (bus_i.wr && bus_i.addr == OFS_INT_EN && !line_settings_o[LS_DIV_SEL]
        |=> interrupt_enable_o == $past(bus_i.wdata[3:0])) else $error("interrupt enable wrong");
    a_trig_off: assert property (rx_trigger_hit_o |-> fifo_ctl_o.enable)
        else $error("trigger without fifo");
endmodule // scr_regs_chk
bind scr_regs scr_regs_chk u_chk (.*);

/* scr_regs_tb_top.sv */
/* Self-checking bench of scr_regs with a queue model of both FIFOs.
   Assumes the host model scr_host and the bound checker. */
`timescale 1ns/1ps
module scr_regs_tb_top;
    import scr_pkg::*;
    logic clock_i, rst_n_i, rx_valid_i, tx_ready_i, rx_ready_o, tx_valid_o;
    logic rx_trigger_hit_o, receive_ready_out_o, transmit_ready_out_o;
    logic [7:0] rdata_o, rx_data_i, tx_data_o, line_state_i, modem_state_i, line_settings_o, v, w;
    logic [3:0] int_id_i, interrupt_enable_o;
    logic [5:0] modem_control_o;
    logic [15:0] divisor_o;
    scr_bus_req_t bus_i;
    scr_fifo_ctl_t fifo_ctl_o;
    logic [7:0] rxq[$], txq[$];
    logic [31:0] lfsr = 32'hEB5DF8FD;
    int num_errors = 0, n_tests = 0, cyc = 0, transmit_holding;
    scr_host host (.clock_i(clock_i), .bus_o(bus_i), .rdata_i(rdata_o));
    scr_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .int_id_i(int_id_i), .line_state_i(line_state_i),
        .modem_state_i(modem_state_i), .divisor_o(divisor_o), .line_settings_o(line_settings_o),
        .modem_control_o(modem_control_o), .interrupt_enable_o(interrupt_enable_o), .fifo_ctl_o(fifo_ctl_o),
        .rx_trigger_hit_o(rx_trigger_hit_o), .receive_ready_out_o(receive_ready_out_o),
        .transmit_ready_out_o(transmit_ready_out_o));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic push_rx(input logic [7:0] d);
        @(negedge clock_i);
        rx_valid_i = 1'b1;
        rx_data_i = d;
        @(negedge clock_i);
        rx_valid_i = 1'b0;
        rx_data_i = ~d;
        rxq.push_back(d);
    endtask
    task automatic pop_tx();
        @(negedge clock_i);
        chk({7'h00, tx_valid_o}, 8'h01);
        chk(tx_data_o, txq.pop_front());
        tx_ready_i = 1'b1;
        @(negedge clock_i);
        tx_ready_i = 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 4000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {rst_n_i, rx_valid_i, tx_ready_i, rx_data_i} = '0;
        int_id_i = 4'hC;
        line_state_i = 8'hE0;
        modem_state_i = rnd();
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'b1;
        rdchk(OFS_LINE_SET, 8'h00);
        rdchk(OFS_MODEM_CTL, 8'h00);
        chk({4'h0, fifo_ctl_o}, 8'h00);
        rdchk(OFS_IDENT, 8'h04);
        rdchk(OFS_LINE_ST, 8'h60);
        rdchk(OFS_MODEM_ST, modem_state_i);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            host.wr(OFS_SCRATCH, v);
            rdchk(OFS_SCRATCH, v);
        end
        host.wr(OFS_INT_EN, 8'hFF);
        rdchk(OFS_INT_EN, 8'h0F);
        host.wr(OFS_MODEM_CTL, 8'hFF);
        rdchk(OFS_MODEM_CTL, 8'h3F);
        chk({2'b00, modem_control_o}, 8'h3F);
        host.wr(OFS_LINE_SET, 8'h80);
        chk(line_settings_o, 8'h80);
        v = rnd();
        w = rnd();
        host.wr(OFS_DATA, v);
        host.wr(OFS_INT_EN, w);
        chk(divisor_o[15:8], w);
        chk(divisor_o[7:0], v);
        rdchk(OFS_INT_EN, w);
        rdchk(OFS_DATA, v);
        host.wr(OFS_LINE_SET, 8'h03);
        rdchk(OFS_INT_EN, 8'h0F);
        for (int t = 0; t < 4; t++) begin
            host.wr(OFS_IDENT, {t[1:0], 6'h33});
            rxq.delete();
            transmit_holding = (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
            chk({4'h0, fifo_ctl_o}, {4'h0, t[1:0], 2'b01});
            chk({7'h00, receive_ready_out_o}, 8'h00);
            rdchk(OFS_IDENT, 8'hCC);
            for (int i = 0; i < 4; i++) begin
                push_rx(rnd());
                chk({7'h00, rx_trigger_hit_o}, {7'h00, rxq.size() >= transmit_holding});
            end
            chk({6'h00, rx_ready_o, transmit_ready_out_o}, 8'h01);
        end
        rdchk(OFS_DATA, rxq.pop_front());
        rdchk(OFS_LINE_ST, 8'hE0);
        host.wr(OFS_IDENT, 8'h48);
        chk({4'h0, fifo_ctl_o}, 8'h0C);
        host.wr(OFS_IDENT, 8'h09);
        rxq.delete();
        chk({6'h00, receive_ready_out_o, transmit_ready_out_o}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            v = rnd();
            host.wr(OFS_DATA, v);
            if (i < 4) txq.push_back(v);
        end
        chk({7'h00, transmit_ready_out_o}, 8'h00);
        pop_tx();
        pop_tx();
        push_rx(rnd());
        host.wr(OFS_IDENT, 8'h0D);
        txq.delete();
        chk({6'h00, tx_valid_o, receive_ready_out_o}, 8'h01);
        host.wr(OFS_IDENT, 8'h01);
        chk({6'h00, receive_ready_out_o, transmit_ready_out_o}, 8'h03);
        rdchk(OFS_DATA, rxq.pop_front());
        test_done();
    end
endmodule // scr_regs_tb_top
